// [core/vemc_core.sv]
// vacuum ejector mode control: modes, regulation, blow-off, calibration
`timescale 1ns/100ps
module vemc_core #(
  parameter int VW        = 10,
  parameter int HOLD_CYC  = vemc_pkg::HOLD_CYC,
  parameter int WIN_CYC   = vemc_pkg::WIN_CYC,
  parameter int STEP_CYC  = vemc_pkg::STEP_CYC,
  parameter int BLINK_CYC = vemc_pkg::BLINK_CYC,
  parameter bit NO_TYPE   = 1'b1
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic [VW-1:0] vac_raw,
  input  wire logic [VW-1:0] leak_rate,
  input  wire logic          leak_valid,
  input  wire logic          in_suction,
  input  wire logic          in_blowoff,
  input  wire logic          serial_mode,
  input  wire logic          pdo_suction,
  input  wire logic          pdo_blowoff,
  input  wire logic          pdo_setup,
  input  wire logic          undervolt,
  input  wire logic          key_suck,
  input  wire logic          key_blow,
  input  wire logic          key_exit,
  output logic               gen_valve,
  output logic               blow_valve,
  output logic               part_present_out,
  output logic               led_h1,
  output logic               led_h2,
  output logic               manual_ind
);

  localparam logic [VW-1:0] ZLIM = VW'(((2 ** VW) - 1) * vemc_pkg::ZERO_PCT / 100);
  localparam logic [27:0] HOLD_N  = 28'(HOLD_CYC);
  localparam logic [27:0] WIN_N   = 28'(WIN_CYC - 1);
  localparam logic [27:0] STEP_N  = 28'(STEP_CYC - 1);
  localparam logic [27:0] BLINK_N = 28'(BLINK_CYC - 1);

  if (VW < 4 || VW > 16 || HOLD_CYC < 1 || WIN_CYC < 1 || STEP_CYC < 1 || BLINK_CYC < 1 ||
      HOLD_CYC >= 2 ** 28 || WIN_CYC >= 2 ** 28 || STEP_CYC >= 2 ** 28 ||
      BLINK_CYC >= 2 ** 28) begin : g_bad_param
    $error("vemc_core: parameter out of range");
  end

  typedef struct packed {
    vemc_pkg::vemc_mode_t mode;
    logic [27:0]   hold_cnt;
    logic          ind;
    logic [2:0]    kq;
    logic [1:0]    in_q;
    logic          suck_q;
    logic          man_suck;
    logic          bt_on;
    logic [27:0]   bt_tick;
    logic [9:0]    bt_cnt;
    logic [27:0]   win_cnt;
    logic [3:0]    sw_cnt;
    logic [1:0]    leak_cnt;
    logic          fb;
    logic          above;
    logic          pp;
    logic [27:0]   blink_cnt;
    logic          blink;
    logic          gen;
    logic          blow;
    logic          po;
    logic [1:0]    ctr;
    logic          shutoff_override;
    logic [1:0]    bmode;
    logic          onc;
    logic [VW-1:0] h1;
    logic [VW-1:0] h1h;
    logic [VW-1:0] h2;
    logic [VW-1:0] h2h;
    logic [9:0]    blowoff_duration;
    logic [VW-1:0] leak_lim;
    logic [VW-1:0] zoff;
    logic          zerr;
    logic          ack;
    logic [31:0]   dat;
  } vemc_st_t;

  vemc_st_t r;
  vemc_st_t n;

  logic          ext_s;
  logic          ext_b;
  logic          suck_req;
  logic          blow_req;
  logic          suck_act;
  logic          regulating;
  logic          cal_wr;
  logic          bt_start;
  logic [VW-1:0] vac;
  logic [VW-1:0] h1_lo;
  logic [VW-1:0] h2_lo;
  logic [2:0]    kedge;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction : hit

  function automatic logic [VW-1:0] sat_sub(input logic [VW-1:0] a, input logic [VW-1:0] b);
    return (a > b) ? VW'(a - b) : '0;
  endfunction : sat_sub

  ////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = r;
    cal_wr   = 1'b0;
    bt_start = 1'b0;
    vac      = sat_sub(vac_raw, r.zoff);
    h1_lo    = sat_sub(r.h1, r.h1h);
    h2_lo    = sat_sub(r.h2, r.h2h);
    ext_s    = serial_mode ? pdo_suction : in_suction;
    ext_b    = serial_mode ? pdo_blowoff : in_blowoff;
    kedge    = {key_exit, key_blow, key_suck} & ~r.kq;
    n.kq     = {key_exit, key_blow, key_suck};
    n.in_q   = {ext_b, ext_s};

    // wishbone slave: one wait state, unmapped reads give zero
    n.ack = 1'b0;
    n.dat = '0;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      n.ack = 1'b1;
      if (hit(wb_adr_i, vemc_pkg::A_CFG)) begin
        n.dat[vemc_pkg::F_CTR +: 2] = r.ctr;
        n.dat[vemc_pkg::F_DCS]      = r.shutoff_override;
        n.dat[vemc_pkg::F_BLO +: 2] = r.bmode;
        n.dat[vemc_pkg::F_ONC]      = r.onc;
      end else if (hit(wb_adr_i, vemc_pkg::A_THR)) begin
        n.dat[VW-1:0]                     = r.h1;
        n.dat[vemc_pkg::F_HI +: VW]       = r.h2;
      end else if (hit(wb_adr_i, vemc_pkg::A_HYS)) begin
        n.dat[VW-1:0]                     = r.h1h;
        n.dat[vemc_pkg::F_HI +: VW]       = r.h2h;
      end else if (hit(wb_adr_i, vemc_pkg::A_BLOW)) begin
        n.dat[9:0] = r.blowoff_duration;
      end else if (hit(wb_adr_i, vemc_pkg::A_LEAK)) begin
        n.dat[VW-1:0] = r.leak_lim;
      end else if (hit(wb_adr_i, vemc_pkg::A_CAL)) begin
        n.dat[VW-1:0] = r.zoff;
      end else if (hit(wb_adr_i, vemc_pkg::A_STAT)) begin
        n.dat[7:0] = {r.zerr, r.fb, r.pp, r.above, r.blow, r.gen, r.mode};
      end
      if (wb_we_i && (&wb_sel_i)) begin
        if (hit(wb_adr_i, vemc_pkg::A_CFG)) begin
          // illegal pairs are refused whole; the old setting stays
          if (wb_dat_i[vemc_pkg::F_CTR +: 2] != 2'h3 &&
              !(wb_dat_i[vemc_pkg::F_CTR +: 2] == vemc_pkg::CTR_OFF &&
                wb_dat_i[vemc_pkg::F_DCS])) begin
            n.ctr = wb_dat_i[vemc_pkg::F_CTR +: 2];
            n.shutoff_override = wb_dat_i[vemc_pkg::F_DCS];
          end
          if (wb_dat_i[vemc_pkg::F_BLO +: 2] != 2'h3) begin
            n.bmode = wb_dat_i[vemc_pkg::F_BLO +: 2];
          end
          n.onc = wb_dat_i[vemc_pkg::F_ONC];
        end
        if (hit(wb_adr_i, vemc_pkg::A_THR)) begin
          n.h1 = wb_dat_i[VW-1:0];
          n.h2 = wb_dat_i[vemc_pkg::F_HI +: VW];
        end
        if (hit(wb_adr_i, vemc_pkg::A_HYS)) begin
          n.h1h = wb_dat_i[VW-1:0];
          n.h2h = wb_dat_i[vemc_pkg::F_HI +: VW];
        end
        if (hit(wb_adr_i, vemc_pkg::A_BLOW) && wb_dat_i[31:10] == '0 &&
            wb_dat_i[9:0] >= vemc_pkg::TBL_MIN &&
            wb_dat_i[9:0] <= vemc_pkg::TBL_MAX) begin
          n.blowoff_duration = wb_dat_i[9:0];
        end
        if (hit(wb_adr_i, vemc_pkg::A_LEAK)) begin
          n.leak_lim = wb_dat_i[VW-1:0];
        end
        if (hit(wb_adr_i, vemc_pkg::A_CAL) && wb_dat_i[0]) begin
          cal_wr = 1'b1;
          // the sensor must sit at ambient; only a small offset is believable
          if (vac_raw <= ZLIM) begin
            n.zoff = vac_raw;
            n.zerr = 1'b0;
          end else begin
            n.zerr = 1'b1;
          end
        end
        if (hit(wb_adr_i, vemc_pkg::A_STAT) && wb_dat_i[0]) begin
          n.zerr = 1'b0;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // operating mode
    n.ind = r.ind & key_suck & key_exit;
    case (r.mode)
      vemc_pkg::MD_AUTO: begin
        if (key_suck && key_exit && !undervolt) begin
          if (r.hold_cnt == HOLD_N) begin
            n.mode     = vemc_pkg::MD_MANUAL;
            n.ind      = 1'b1;
            n.hold_cnt = '0;
            n.man_suck = r.suck_q;
          end else begin
            n.hold_cnt = r.hold_cnt + 28'h0000001;
          end
        end else begin
          n.hold_cnt = '0;
        end
        if (serial_mode && pdo_setup && !pdo_suction && !pdo_blowoff) begin
          n.mode     = vemc_pkg::MD_SETUP;
          n.hold_cnt = '0;
        end
      end
      vemc_pkg::MD_MANUAL: begin
        if (kedge[0]) begin
          n.man_suck = !r.man_suck;
        end
        if (kedge[1]) begin
          n.man_suck = 1'b0;
        end
        if (kedge[2] || {ext_b, ext_s} != r.in_q || undervolt) begin
          n.mode = vemc_pkg::MD_AUTO;
        end
      end
      vemc_pkg::MD_SETUP: begin
        if (!(serial_mode && pdo_setup && !pdo_suction && !pdo_blowoff)) begin
          n.mode = vemc_pkg::MD_AUTO;
        end
      end
      default: n.mode = vemc_pkg::MD_AUTO;
    endcase

    ////////////////////////////////////////////////////////////////////////////////////////
    // suction and blow-off requests
    suck_req = (r.mode == vemc_pkg::MD_MANUAL) ? r.man_suck : ext_s;
    n.suck_q = suck_req;
    case (r.bmode)
      vemc_pkg::BLO_INT:   bt_start = r.suck_q && !suck_req;
      vemc_pkg::BLO_PULSE: bt_start = ext_b && !r.in_q[1];
      default:             bt_start = 1'b0;
    endcase
    if (r.mode == vemc_pkg::MD_MANUAL) begin
      // a running timed pulse is carried into manual mode untouched
      blow_req = key_blow || r.bt_on;
      bt_start = 1'b0;
    end else begin
      case (r.bmode)
        vemc_pkg::BLO_INT:   blow_req = ext_b || r.bt_on;
        vemc_pkg::BLO_PULSE: blow_req = r.bt_on;
        default:             blow_req = ext_b;
      endcase
    end

    // blow-off timer in 10 ms steps; a new start reloads it
    if (bt_start) begin
      n.bt_on   = 1'b1;
      n.bt_cnt  = r.blowoff_duration;
      n.bt_tick = '0;
    end else if (r.bt_on) begin
      if (r.bt_tick == STEP_N) begin
        n.bt_tick = '0;
        n.bt_cnt  = r.bt_cnt - 10'h001;
        if (r.bt_cnt == 10'h001) begin
          n.bt_on = 1'b0;
        end
      end else begin
        n.bt_tick = r.bt_tick + 28'h0000001;
      end
    end

    suck_act = suck_req && !blow_req;

    ////////////////////////////////////////////////////////////////////////////////////////
    // regulation with hysteresis
    if (vac >= r.h1) begin
      n.above = 1'b1;
    end else if (vac < h1_lo) begin
      n.above = 1'b0;
    end
    regulating = suck_act && r.ctr != vemc_pkg::CTR_OFF && !r.fb;

    // switching frequency window; protection off in manual and set-up
    n.win_cnt = (r.win_cnt == WIN_N) ? '0 : r.win_cnt + 28'h0000001;
    if (r.win_cnt == WIN_N) begin
      n.sw_cnt = '0;
    end else if (regulating && !n.above && r.above && r.sw_cnt != 4'hf) begin
      n.sw_cnt = r.sw_cnt + 4'h1;
    end
    if (r.sw_cnt > 4'(vemc_pkg::SW_MAX) && !r.shutoff_override &&
        r.mode == vemc_pkg::MD_AUTO && regulating) begin
      n.fb = 1'b1;
    end

    // leak check stays active in manual mode
    if (leak_valid && suck_act && r.ctr == vemc_pkg::CTR_LEAK) begin
      if (leak_rate > r.leak_lim) begin
        if (r.leak_cnt != 2'h3) begin
          n.leak_cnt = r.leak_cnt + 2'h1;
        end
        if (r.leak_cnt >= 2'(vemc_pkg::LEAK_MAX) && !r.shutoff_override) begin
          n.fb = 1'b1;
        end
      end else begin
        n.leak_cnt = '0;
      end
    end
    if (!suck_req) begin
      n.fb       = 1'b0;
      n.leak_cnt = '0;
    end

    // valves; the fallback only ever adds suction
    if (undervolt) begin
      n.gen  = NO_TYPE;
      n.blow = 1'b0;
    end else begin
      n.gen  = suck_act && (r.ctr == vemc_pkg::CTR_OFF || r.fb || !n.above);
      n.blow = blow_req;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // part present comparison, keeps working under undervoltage
    if (vac > r.h2) begin
      n.pp = 1'b1;
    end else if (vac < h2_lo) begin
      n.pp = 1'b0;
    end
    n.po = n.pp ^ n.onc;

    n.blink_cnt = (r.blink_cnt == BLINK_N) ? '0 : r.blink_cnt + 28'h0000001;
    if (r.blink_cnt == BLINK_N) begin
      n.blink = !r.blink;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r       <= '0;
      r.mode  <= vemc_pkg::MD_AUTO;
      r.ctr   <= vemc_pkg::CTR_RST;
      r.bmode <= vemc_pkg::BLO_RST;
      r.blowoff_duration   <= vemc_pkg::TBL_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  assign wb_ack_o         = r.ack;
  assign wb_dat_o         = r.dat;
  assign gen_valve        = r.gen;
  assign blow_valve       = r.blow;
  assign part_present_out = r.po;
  assign manual_ind       = r.ind;
  assign led_h1 = (r.mode != vemc_pkg::MD_AUTO) ? r.blink : r.above;
  assign led_h2 = (r.mode != vemc_pkg::MD_AUTO) ? r.blink : r.pp;

  ////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_bus_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");
  a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_manual_hold_time: assert property (
    r.mode == vemc_pkg::MD_MANUAL && $past(r.mode) == vemc_pkg::MD_AUTO
    |-> $past(r.hold_cnt) == HOLD_N && manual_ind)
    else $error("manual mode entered without full hold");
  a_manual_exit_key: assert property (
    r.mode == vemc_pkg::MD_MANUAL && key_exit && !r.kq[2] |=> r.mode == vemc_pkg::MD_AUTO)
    else $error("exit key did not leave manual mode");
  a_leds_blink_both: assert property (
    r.mode != vemc_pkg::MD_AUTO && n.mode != vemc_pkg::MD_AUTO && r.blink_cnt == BLINK_N
    |=> led_h1 != $past(led_h1) && led_h2 != $past(led_h2))
    else $error("threshold leds not blinking");
  a_blow_follow: assert property (
    r.mode == vemc_pkg::MD_AUTO && r.bmode == vemc_pkg::BLO_EXT && !undervolt && !serial_mode
    |=> blow_valve == $past(in_blowoff))
    else $error("blow-off does not follow input");
  a_blow_load_time: assert property (
    $rose(r.bt_on) |-> r.bt_cnt == $past(r.blowoff_duration) && r.bt_tick == '0)
    else $error("blow-off timer loaded wrongly");
  a_zero_refuse: assert property (
    cal_wr && vac_raw > ZLIM |=> r.zerr && $stable(r.zoff))
    else $error("out of range calibration accepted");
  a_reg_cut_off: assert property (
    suck_act && r.ctr == vemc_pkg::CTR_ON && !r.fb && !undervolt && vac >= r.h1
    |=> !gen_valve)
    else $error("generator on above threshold");
  a_cont_suction: assert property (
    suck_act && r.ctr == vemc_pkg::CTR_OFF && !undervolt |=> gen_valve)
    else $error("no continuous suction with regulation off");
  a_undervolt_idle: assert property (
    undervolt |=> gen_valve == NO_TYPE && !blow_valve)
    else $error("undervoltage state wrong");
  a_ovr_legal: assert property (
    !(r.ctr == vemc_pkg::CTR_OFF && r.shutoff_override))
    else $error("override set with regulation off");

endmodule : vemc_core

// [core/vemc_pkg.sv]
// constants shared by the vacuum ejector mode control
package vemc_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_THR  = 8'h04;
  localparam logic [7:0] A_HYS  = 8'h08;
  localparam logic [7:0] A_BLOW = 8'h0c;
  localparam logic [7:0] A_LEAK = 8'h10;
  localparam logic [7:0] A_CAL  = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  // cfg field positions; F_HI is the upper half of thr and hys
  localparam int F_CTR  = 0;
  localparam int F_DCS  = 2;
  localparam int F_BLO  = 3;
  localparam int F_ONC  = 5;
  localparam int F_HI   = 16;
  // air-saving settings
  localparam logic [1:0] CTR_OFF  = 2'h0;
  localparam logic [1:0] CTR_ON   = 2'h1;
  localparam logic [1:0] CTR_LEAK = 2'h2;
  // blow-off settings
  localparam logic [1:0] BLO_EXT   = 2'h0;
  localparam logic [1:0] BLO_INT   = 2'h1;
  localparam logic [1:0] BLO_PULSE = 2'h2;
  // reset values
  localparam logic [1:0] CTR_RST = 2'h1;
  localparam logic [1:0] BLO_RST = 2'h0;
  localparam logic [9:0] TBL_RST = 10'h032;
  // blow-off duration limits in 10 ms steps
  localparam logic [9:0] TBL_MIN = 10'h00a;
  localparam logic [9:0] TBL_MAX = 10'h3e7;
  // limits of the monitors
  localparam int SW_MAX   = 6;
  localparam int LEAK_MAX = 2;
  localparam int ZERO_PCT = 3;
  // times
  localparam int CLK_HZ   = 50_000_000;
  localparam int HOLD_MS  = 3000;
  localparam int WIN_MS   = 3000;
  localparam int STEP_MS  = 10;
  localparam int BLINK_MS = 250;
  localparam int HOLD_CYC  = CLK_HZ / 1000 * HOLD_MS;
  localparam int WIN_CYC   = CLK_HZ / 1000 * WIN_MS;
  localparam int STEP_CYC  = CLK_HZ / 1000 * STEP_MS;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  // operating modes
  typedef enum logic [1:0] {
    MD_AUTO   = 2'b00,
    MD_MANUAL = 2'b01,
    MD_SETUP  = 2'b10
  } vemc_mode_t;
endpackage : vemc_pkg

// [dv/vemc_vac_model.sv]
// behavioural vacuum circuit driven by the ejector valves
`timescale 1ns/100ps
module vemc_vac_model (
  input  wire logic       core_clk,
  input  wire logic       gen_valve,
  input  wire logic       blow_valve,
  input  wire logic       hold_en,
  input  wire logic [9:0] hold_val,
  output logic      [9:0] vac
);
  // fast rise and slow leak so regulation cycles within a short window
  always_ff @(posedge core_clk) begin
    if (hold_en) begin
      vac <= hold_val;
    end else if (blow_valve) begin
      vac <= 10'h000;
    end else if (gen_valve) begin
      vac <= (vac > 10'h3f0) ? 10'h3ff : vac + 10'h00a;
    end else begin
      vac <= (vac < 10'h003) ? 10'h000 : vac - 10'h003;
    end
  end
endmodule : vemc_vac_model

// [dv/testbench.sv]
// self-checking bench for the vacuum ejector mode control
`timescale 1ns/100ps
module testbench;
  localparam int STEP = 4;
  logic        core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [9:0]  vac_raw, leak_rate, hv;
  logic        hold, leak_valid, in_suction, in_blowoff, serial_mode, pdo_suction;
  logic        pdo_blowoff, pdo_setup, undervolt, key_suck, key_blow, key_exit;
  logic        gen_valve, blow_valve, part_present_out, led_h1, led_h2, manual_ind, a;
  int          n_fail, checks_done, c;
  int          bw[4] = '{9, 1000, 999, 10};
  int          be[4] = '{50, 50, 999, 10};
  int          vv[6] = '{50, 100, 95, 89, 58, 54};
  logic        ge[6] = '{1, 0, 0, 1, 1, 1};
  logic        pe[6] = '{0, 1, 1, 1, 1, 0};

  // one regulation swing of the model takes 13 cycles, so a full window sees over six
  vemc_core #(.HOLD_CYC(20), .WIN_CYC(128), .STEP_CYC(STEP), .BLINK_CYC(4)) i_dut (
    .core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .vac_raw, .leak_rate, .leak_valid,
    .in_suction, .in_blowoff, .serial_mode, .pdo_suction, .pdo_blowoff,
    .pdo_setup, .undervolt, .key_suck, .key_blow, .key_exit, .gen_valve,
    .blow_valve, .part_present_out, .led_h1, .led_h2, .manual_ind);
  vemc_vac_model i_vac (.core_clk, .gen_valve, .blow_valve, .hold_en(hold),
    .hold_val(hv), .vac(vac_raw));

  ////////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tk
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic cnt_blow;
    c = 0;
    repeat (100) begin
      @(posedge core_clk);
      if (blow_valve === 1'b1) c++;
    end
  endtask : cnt_blow

  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // generous span: the whole sequence needs well under two thousand cycles
  initial begin
    tk(20000);
    n_fail++;
    finish_test();
  end

  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, leak_valid, in_suction, in_blowoff} = '0;
    {serial_mode, pdo_suction, pdo_blowoff, pdo_setup, undervolt} = '0;
    {key_suck, key_blow, key_exit, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {leak_rate, hv} = '0;
    hold = 1'b1;
    tk(10);
    rstn <= 1'b1;
    wb(0, 8'h00, 0); chk(q, 32'h1);
    wb(0, 8'h0c, 0); chk(q, 32'h32);
    wb(1, 8'h1c, 32'h5); wb(0, 8'h1c, 0); chk(q, 0);
    wb(1, 8'h00, 32'h3); wb(0, 8'h00, 0); chk(q, 32'h1);
    wb(1, 8'h00, 32'h4); wb(0, 8'h00, 0); chk(q, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wb(1, 8'h0c, bw[i]); wb(0, 8'h0c, 0); chk(q, be[i]);
    end
    wb(1, 8'h04, 32'h003c0064);
    wb(1, 8'h08, 32'h0005000a);
    in_suction <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      hv <= vv[i];
      tk(3);
      chk(gen_valve, ge[i]);
      chk(part_present_out, pe[i]);
    end
    wb(1, 8'h00, 32'h21); tk(2); chk(part_present_out, 1);
    wb(1, 8'h00, 32'h0); hv <= 10'd200; tk(3); chk(gen_valve, 1);
    wb(1, 8'h00, 32'h5); wb(0, 8'h00, 0); chk(q, 32'h5);
    wb(1, 8'h00, 32'h1); hv <= 10'h0; tk(3);
    key_suck <= 1'b1; key_exit <= 1'b1;
    tk(12); wb(0, 8'h18, 0); chk(q[1:0], 0);
    tk(10); wb(0, 8'h18, 0); chk(q[1:0], 1);
    chk(manual_ind, 1); chk(gen_valve, 1);
    a = led_h1; tk(4); chk(led_h1, !a);
    a = led_h2; tk(4); chk(led_h2, !a);
    key_suck <= 1'b0; key_exit <= 1'b0; tk(2);
    key_suck <= 1'b1; tk(3); chk(gen_valve, 0);
    key_suck <= 1'b0; tk(2);
    key_suck <= 1'b1; tk(3); chk(gen_valve, 1);
    key_suck <= 1'b0; key_blow <= 1'b1; tk(3);
    chk(gen_valve, 0); chk(blow_valve, 1);
    key_blow <= 1'b0; tk(3); chk(blow_valve, 0);
    key_exit <= 1'b1; tk(2); wb(0, 8'h18, 0); chk(q[1:0], 0);
    key_suck <= 1'b1; tk(25); key_suck <= 1'b0; key_exit <= 1'b0;
    wb(0, 8'h18, 0); chk(q[1:0], 1);
    in_suction <= 1'b0; tk(2); wb(0, 8'h18, 0); chk(q[1:0], 0);
    undervolt <= 1'b1; tk(3); chk({gen_valve, blow_valve}, 2'b10);
    undervolt <= 1'b0;
    serial_mode <= 1'b1; pdo_setup <= 1'b1; tk(3);
    wb(0, 8'h18, 0); chk(q[1:0], 2);
    pdo_suction <= 1'b1; tk(3); wb(0, 8'h18, 0); chk(q[1:0], 0);
    {serial_mode, pdo_suction, pdo_setup} <= 3'b0;
    in_blowoff <= 1'b1; tk(3); chk(blow_valve, 1);
    in_blowoff <= 1'b0; tk(3); chk(blow_valve, 0);
    wb(1, 8'h00, 32'h11); in_blowoff <= 1'b1; cnt_blow();
    chk(c, 10 * STEP);
    in_blowoff <= 1'b0;
    wb(1, 8'h00, 32'h09); in_suction <= 1'b1; tk(3);
    in_suction <= 1'b0; cnt_blow(); chk(c, 10 * STEP);
    in_blowoff <= 1'b1; tk(3); chk(blow_valve, 1);
    in_blowoff <= 1'b0;
    wb(1, 8'h00, 32'h01); hold <= 1'b0; in_suction <= 1'b1; tk(400);
    wb(0, 8'h18, 0); chk(q[6], 1);
    // vacuum back to zero so regulation swings again within the run
    in_suction <= 1'b0; hold <= 1'b1; wb(1, 8'h00, 32'h05);
    hold <= 1'b0; in_suction <= 1'b1; tk(400);
    wb(0, 8'h18, 0); chk(q[6], 0);
    in_suction <= 1'b0; hold <= 1'b1; wb(1, 8'h00, 32'h02);
    wb(1, 8'h10, 32'h5); leak_rate <= 10'd9; in_suction <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wb(0, 8'h18, 0); chk(q[6], 0);
      leak_valid <= 1'b1; tk(1); leak_valid <= 1'b0; tk(2);
    end
    wb(0, 8'h18, 0); chk(q[6], 1); chk(gen_valve, 1);
    in_suction <= 1'b0; hv <= 10'd30; tk(3);
    wb(1, 8'h14, 32'h1); wb(0, 8'h14, 0); chk(q, 30);
    wb(0, 8'h18, 0); chk(q[7], 0);
    hv <= 10'd61; tk(2); wb(1, 8'h14, 32'h1);
    wb(0, 8'h18, 0); chk(q[7], 1);
    wb(0, 8'h14, 0); chk(q, 30);
    finish_test();
  end
endmodule : testbench
